// ---- tmid_core.sv ----
// transport move core: decode, execution, pointers, stack, pins, registers
`timescale 1ns/1ns
module tmid_core (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [tmid_pkg::AXW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [tmid_pkg::AXW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic [tmid_pkg::IW-1:0] code_addr,
  output logic code_from_data,
  input wire logic [tmid_pkg::IW-1:0] instr,
  output tmid_pkg::tmid_mreq_t dmem,
  input wire logic [tmid_pkg::IW-1:0] dmem_rdata,
  output tmid_pkg::tmid_preg_t preg,
  input wire logic [tmid_pkg::IW-1:0] preg_rdata,
  input wire logic [tmid_pkg::PWD_WORDS*tmid_pkg::IW-1:0] pwd_words,
  output logic prog_access_en,
  output logic core_reset,
  input wire logic rpin_in,
  output logic rpin_out,
  output logic rpin_oe_n,
  output logic rpin_pullup,
  input wire logic [tmid_pkg::PW-1:0] port_in,
  output logic [tmid_pkg::PW-1:0] port_out,
  output logic [tmid_pkg::PW-1:0] port_oe_n,
  output logic [tmid_pkg::PW-1:0] port_pullup
);
  import tmid_pkg::*;

  function automatic logic is_int(input logic [MODW-1:0] m);
    is_int = (m >= MOD_AP && m != MOD_RSVD) || m == MOD_PORT ||
             m == MOD_MEM;
  endfunction

  logic [7:0] ctrl_q;
  logic [IW-1:0] pc_q;
  logic [AW-1:0] pfx_q;
  logic [MODW-1:0] ap_q;
  logic [AW-1:0] acc_q [NACC];
  logic carry_q;
  logic [1:0] sp_q;
  logic [IW-1:0] stk_q [NSTK];
  logic [IW-1:0] dp_q [NDP];
  logic [PW-1:0] pout_q, pdir_q;
  logic rp_out_q, rp_dir_q;
  logic [IW-1:0] src_val;
  logic [AW:0] alu_res;
  tmid_alu_t alu_op;

  // ************************************************
  // pin synchronisers
  // ************************************************
  logic [2:0] rpin_s_q;
  logic rpin_f_q;
  logic [PW-1:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_f_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rpin_s_q <= '1;
      rpin_f_q <= 1'b1;
      pin_s1_q <= '1;
      pin_s2_q <= '1;
      pin_s3_q <= '1;
      pin_f_q <= '1;
    end else begin
      rpin_s_q <= {rpin_s_q[1:0], rpin_in};
      if (rpin_s_q[1] == rpin_s_q[2]) begin
        rpin_f_q <= rpin_s_q[2];
      end
      pin_s1_q <= port_in;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      // per bit: accept only when second and third stages agree
      pin_f_q <= (pin_s2_q & pin_s3_q) | (pin_f_q & (pin_s2_q | pin_s3_q));
    end
  end

  wire reset_pin_disable_bit = ctrl_q[CTRL_RESET_PIN_DISABLE_BIT];
  wire pin_rst = !reset_pin_disable_bit && !rpin_f_q;
  wire core_rst = !aresetn || pin_rst;
  wire exec = ctrl_q[CTRL_RUN] && !core_rst;
  assign core_reset = core_rst;

  // ************************************************
  // instruction decode
  // ************************************************
  wire src_reg = instr[FMT_BIT] == FMT_REG;
  wire [AW-1:0] imm = instr[SRC_LSB +: AW];
  wire [MODW-1:0] src_mod = instr[SRC_LSB +: MODW];
  wire [MODW-1:0] src_idx = instr[SIDX_LSB +: MODW];
  wire [4:0] src_idx5 = {1'b0, src_idx};
  wire [MODW-1:0] dst_mod = instr[DST_LSB +: MODW];
  wire [SUBW-1:0] dst_sub = instr[SUB_LSB +: SUBW];
  wire [4:0] dst_idx = {pfx_q[PFX_DST_LSB +: PFXW], dst_sub};

  // every operation is a move; side effects hang off the addresses
  wire wr_pfx = exec && dst_mod == MOD_PFX;
  wire wr_ap = exec && dst_mod == MOD_AP && dst_idx == IDX_AP;
  wire wr_acc = exec && dst_mod == MOD_ACC;
  wire wr_alu = exec && dst_mod == MOD_ALU;
  wire wr_jmp = exec && dst_mod == MOD_IP && dst_idx == IDX_JUMP;
  wire wr_call = exec && dst_mod == MOD_IP && dst_idx == IDX_CALL;
  wire wr_push = exec && dst_mod == MOD_STK && dst_idx == IDX_STACK;
  wire wr_sp = exec && dst_mod == MOD_STK && dst_idx == IDX_SP;
  wire wr_dp = exec && dst_mod == MOD_DP;
  wire wr_mem = exec && dst_mod == MOD_MEM;
  wire wr_port = exec && dst_mod == MOD_PORT;
  wire rd_stk = src_reg && src_mod == MOD_STK;
  wire rd_pop = exec && rd_stk && src_idx5 == IDX_STACK;
  wire rd_mem = exec && src_reg && src_mod == MOD_MEM;

  // ************************************************
  // data pointers and data memory
  // ************************************************
  // one port: when both ends are memory the destination pointer wins
  wire [1:0] mem_ptr = wr_mem ? dst_idx[1:0] : src_idx[1:0];
  wire mem_pre = wr_mem ? dst_idx[PM_PRE_BIT] : src_idx[PM_PRE_BIT];
  wire mem_dec = wr_mem ? dst_idx[PM_DEC_BIT] : src_idx[PM_DEC_BIT];
  wire ptr_ok = mem_ptr < 2'(NDP);
  wire mem_act = (wr_mem || rd_mem) && ptr_ok;
  wire [IW-1:0] dp_sel = ptr_ok ? dp_q[mem_ptr] : PTR_RESET;
  wire [IW-1:0] dp_step = mem_dec ? dp_sel - WORD_STEP :
                          dp_sel + WORD_STEP;
  wire [IW-1:0] mem_addr = mem_pre ? dp_step : dp_sel;
  wire [1:0] mm = ctrl_q[CTRL_MM_LSB +: 2];

  assign dmem.req = mem_act;
  assign dmem.we = wr_mem && ptr_ok;
  assign dmem.code_space = mm == MM_CODE_IN_DATA &&
                           mem_addr >= CODE_DATA_BASE;
  assign dmem.addr = mem_addr;
  assign dmem.wdata = src_val;

  genvar gi;
  generate
    for (gi = 0; gi < NDP; gi++) begin : g_dp
      always_ff @(posedge aclk) begin
        if (core_rst) begin
          dp_q[gi] <= PTR_RESET;
        end else if (wr_dp && dst_idx == 5'(gi)) begin
          dp_q[gi] <= src_val;
        end else if (mem_act && mem_ptr == 2'(gi)) begin
          dp_q[gi] <= dp_step;
        end
      end
    end
  endgenerate

  // ************************************************
  // source selection and alu
  // ************************************************
  wire [AW-1:0] acc_a = acc_q[ap_q];
  wire [IW-1:0] dp_rd = src_idx[1:0] < 2'(NDP) ? dp_q[src_idx[1:0]] :
                        PTR_RESET;
  wire [IW-1:0] stk_rd = src_idx5 == IDX_SP ? IW'(sp_q) : stk_q[sp_q];
  wire [IW-1:0] port_rd =
    src_idx5 == IDX_POUT ? IW'(pout_q) :
    src_idx5 == IDX_PDIR ? IW'(pdir_q) :
    src_idx5 == IDX_PIN ? IW'(pin_f_q) :
    IW'({rp_dir_q, rpin_f_q});

  always_comb begin
    src_val = IW'(imm);
    if (src_reg) begin
      case (src_mod)
        MOD_AP: src_val = IW'(ap_q);
        MOD_ACC: src_val = IW'(acc_q[src_idx]);
        MOD_ALU: src_val = IW'(carry_q);
        MOD_PFX: src_val = IW'(pfx_q);
        MOD_IP: src_val = pc_q;
        MOD_STK: src_val = stk_rd;
        MOD_DP: src_val = dp_rd;
        MOD_MEM: src_val = dmem_rdata;
        MOD_PORT: src_val = port_rd;
        default: src_val = preg_rdata;
      endcase
    end
  end

  assign alu_op = tmid_alu_t'(dst_sub);
  wire [AW-1:0] opnd = src_val[AW-1:0];
  wire alu_arith = alu_op == ALU_ADD || alu_op == ALU_SUB;

  always_comb begin
    case (alu_op)
      ALU_ADD: alu_res = {1'b0, acc_a} + {1'b0, opnd};
      ALU_SUB: alu_res = {1'b0, acc_a} - {1'b0, opnd};
      ALU_AND: alu_res = {1'b0, acc_a & opnd};
      ALU_OR: alu_res = {1'b0, acc_a | opnd};
      ALU_XOR: alu_res = {1'b0, acc_a ^ opnd};
      default: alu_res = {1'b0, opnd};
    endcase
  end

  // other modules sit on the peripheral strobe, same cycle
  assign preg.wr = exec && !is_int(dst_mod);
  assign preg.rd = exec && src_reg && !is_int(src_mod);
  assign preg.mod = src_reg && !is_int(src_mod) && !preg.wr ?
                    src_mod : dst_mod;
  assign preg.idx = preg.wr ? dst_idx : src_idx5;
  assign preg.wdata = src_val;

  // ************************************************
  // program counter, prefix, accumulators
  // ************************************************
  assign code_addr = pc_q;
  assign code_from_data = mm == MM_DATA_IN_CODE &&
                          pc_q >= DATA_CODE_BASE;

  always_ff @(posedge aclk) begin
    if (core_rst) begin
      pc_q <= PC_RESET;
      pfx_q <= '0;
      ap_q <= '0;
      carry_q <= 1'b0;
    end else if (exec) begin
      pc_q <= wr_jmp || wr_call ? src_val : pc_q + WORD_STEP;
      // held for one instruction only
      pfx_q <= wr_pfx ? src_val[AW-1:0] : '0;
      if (wr_ap) begin
        ap_q <= src_val[MODW-1:0];
      end
      if (wr_alu && alu_arith) begin
        carry_q <= alu_res[AW];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (core_rst) begin
      for (int i = 0; i < NACC; i++) begin
        acc_q[i] <= '0;
      end
    end else if (wr_acc) begin
      acc_q[dst_idx[MODW-1:0]] <= src_val[AW-1:0];
    end else if (wr_alu) begin
      acc_q[ap_q] <= alu_res[AW-1:0];
    end
  end

  // ************************************************
  // hardware stack
  // ************************************************
  // pop first, then push: a stack-to-stack move rewrites the top
  wire [1:0] sp_base = rd_pop ? sp_q - SP_STEP : sp_q;
  wire [1:0] sp_push = sp_base + SP_STEP;
  wire push = wr_push || wr_call;
  wire [IW-1:0] push_val = wr_call ? pc_q + WORD_STEP : src_val;

  always_ff @(posedge aclk) begin
    if (core_rst) begin
      sp_q <= SP_RESET;
    end else if (wr_sp) begin
      sp_q <= src_val[1:0];
    end else if (push) begin
      sp_q <= sp_push;
    end else begin
      sp_q <= sp_base;
    end
  end

  always_ff @(posedge aclk) begin
    if (push) begin
      stk_q[sp_push] <= push_val;
    end
  end

  // ************************************************
  // port pins
  // ************************************************
  always_ff @(posedge aclk) begin
    if (core_rst) begin
      pout_q <= '0;
      pdir_q <= '0;
      rp_out_q <= 1'b0;
      rp_dir_q <= 1'b0;
    end else if (wr_port) begin
      if (dst_idx == IDX_POUT) begin
        pout_q <= src_val[PW-1:0];
      end
      if (dst_idx == IDX_PDIR) begin
        pdir_q <= src_val[PW-1:0];
      end
      if (dst_idx == IDX_RPIN) begin
        rp_out_q <= src_val[RP_OUT_BIT];
        rp_dir_q <= src_val[RP_DIR_BIT];
      end
    end
  end

  assign port_out = pout_q;
  assign port_oe_n = ~pdir_q;
  assign port_pullup = ~pdir_q;
  assign rpin_out = rp_out_q;
  assign rpin_oe_n = !(reset_pin_disable_bit && rp_dir_q);
  assign rpin_pullup = rpin_oe_n;

  // ************************************************
  // register bus slave
  // ************************************************
  logic aw_held_q, w_held_q, bvalid_q, rvalid_q;
  logic [AXW-1:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [4:0] kcnt_q;
  logic kbad_q, unlocked_q;

  assign awready = !aw_held_q;
  assign wready = !w_held_q;
  assign arready = !rvalid_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  wire do_wr = aw_held_q && w_held_q && !bvalid_q;
  wire wr_hit = awaddr_q == REG_CTRL || awaddr_q == REG_KEY;
  wire wr_ctrl = do_wr && awaddr_q == REG_CTRL && wstrb_q[0];
  wire wr_key = do_wr && awaddr_q == REG_KEY && &wstrb_q[1:0];
  wire rd_hit = araddr == REG_CTRL || araddr == REG_STAT ||
                araddr == REG_PC || araddr == REG_KEY ||
                araddr == REG_ACC;
  wire [31:0] stat_word = 32'({kbad_q, carry_q, unlocked_q, sp_q});
  wire [31:0] rd_word =
    araddr == REG_CTRL ? 32'(ctrl_q) :
    araddr == REG_STAT ? stat_word :
    araddr == REG_PC ? 32'(pc_q) :
    araddr == REG_ACC ? 32'({ap_q, acc_a}) : 32'h00000000;
  wire [IW-1:0] key_ref = pwd_words[kcnt_q[3:0]*IW +: IW];
  wire key_ok = wdata_q[IW-1:0] == key_ref;
  wire key_full = kcnt_q == KEY_DONE;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      bvalid_q <= 1'b0;
      rvalid_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bresp_q <= RESP_OKAY;
      rresp_q <= RESP_OKAY;
      rdata_q <= '0;
    end else begin
      if (awvalid && !aw_held_q) begin
        aw_held_q <= 1'b1;
        awaddr_q <= awaddr;
      end else if (do_wr) begin
        aw_held_q <= 1'b0;
      end
      if (wvalid && !w_held_q) begin
        w_held_q <= 1'b1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end else if (do_wr) begin
        w_held_q <= 1'b0;
      end
      if (do_wr) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid_q <= 1'b0;
      end
      if (arvalid && !rvalid_q) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_word;
        rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // control survives the pin reset: only power-on clears it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CTRL_RESET;
      kcnt_q <= '0;
      kbad_q <= 1'b0;
      unlocked_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= wdata_q[7:0];
      end
      if (wr_key && key_full) begin
        kcnt_q <= '0;
        kbad_q <= 1'b0;
        unlocked_q <= 1'b0;
      end else if (wr_key) begin
        kcnt_q <= kcnt_q + KEY_STEP;
        kbad_q <= kbad_q || !key_ok;
        unlocked_q <= kcnt_q == KEY_DONE - KEY_STEP && key_ok && !kbad_q;
      end
    end
  end

  assign prog_access_en = !ctrl_q[CTRL_PWL] || unlocked_q;

  // ************************************************
  // checks
  // ************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_pfx_then;
    wr_pfx ##1 (exec && !wr_pfx);
  endsequence

  chk_pfx_clears: assert property (s_pfx_then |=> pfx_q == '0)
    else $error("prefix outlived the next instruction");
  chk_pfx_index: assert property (wr_pfx ##1 exec |->
    dst_idx[4:3] == $past(src_val[1:0]))
    else $error("prefix bits not in destination index");
  chk_sp_reset: assert property (core_rst |=> sp_q == SP_RESET)
    else $error("stack pointer not at top after reset");
  chk_push_order: assert property (
    wr_push && !rd_pop |=> sp_q == $past(sp_q) + SP_STEP &&
    stk_q[sp_q] == $past(src_val))
    else $error("push did not increment then store");
  chk_pop_order: assert property (
    rd_pop && !push && !wr_sp |-> src_val == stk_q[sp_q]
    ##1 sp_q == $past(sp_q) - SP_STEP)
    else $error("pop did not read then decrement");
  chk_pc_step: assert property (
    exec && !wr_jmp && !wr_call |=> pc_q == $past(pc_q) + WORD_STEP)
    else $error("pc did not advance by one word");
  chk_jump_load: assert property (wr_jmp |=> pc_q == $past(src_val))
    else $error("jump target not loaded");
  chk_alu_add: assert property (
    wr_alu && alu_op == ALU_ADD |=>
    acc_q[$past(ap_q)] == AW'($past(acc_a) + $past(opnd)))
    else $error("add result wrong");
  chk_ptr_step: assert property (
    mem_act && !wr_dp |=> dp_q[$past(mem_ptr)] == $past(dp_step))
    else $error("pointer did not step after access");
  chk_rst_pin: assert property (
    !reset_pin_disable_bit && !rpin_f_q |-> core_rst && rpin_oe_n)
    else $error("shared pin not acting as reset");
  chk_port_dflt: assert property (
    core_rst |=> &port_oe_n && &port_pullup)
    else $error("ports not inputs with pullup after reset");
  chk_key_lock: assert property (
    ctrl_q[CTRL_PWL] && !key_full |-> !prog_access_en)
    else $error("code access open before key matched");
endmodule

// ---- tmid_pkg.sv ----
// package: constants and types for the transport move core
package tmid_pkg;
  localparam int IW = 16;
  localparam int AW = 8;
  localparam int NACC = 16;
  localparam int NSTK = 4;
  localparam int NDP = 3;
  localparam int PW = 8;
  localparam int PWD_WORDS = 16;
  localparam int MODW = 4;
  localparam int SUBW = 3;
  localparam int PFXW = 2;
  localparam int FMT_BIT = 15;
  localparam int SRC_LSB = 0;
  localparam int SIDX_LSB = 4;
  localparam int DST_LSB = 8;
  localparam int SUB_LSB = 12;
  localparam int PFX_DST_LSB = 0;
  localparam int PM_DEC_BIT = 2;
  localparam int PM_PRE_BIT = 3;
  localparam int RP_OUT_BIT = 0;
  localparam int RP_DIR_BIT = 1;
  localparam logic FMT_REG = 1'b1;
  localparam logic [1:0] SP_RESET = 2'h3;
  localparam logic [1:0] SP_STEP = 2'h1;
  localparam logic [IW-1:0] PC_RESET = 16'h0000;
  localparam logic [IW-1:0] PTR_RESET = 16'h0000;
  localparam logic [IW-1:0] WORD_STEP = 16'h0001;
  localparam logic [4:0] KEY_DONE = 5'h10;
  localparam logic [4:0] KEY_STEP = 5'h01;
  // module specifiers of the instruction fields
  localparam logic [3:0] MOD_PORT = 4'h1;
  localparam logic [3:0] MOD_MEM = 4'h7;
  localparam logic [3:0] MOD_AP = 4'h8;
  localparam logic [3:0] MOD_ACC = 4'h9;
  localparam logic [3:0] MOD_ALU = 4'ha;
  localparam logic [3:0] MOD_PFX = 4'hb;
  localparam logic [3:0] MOD_IP = 4'hc;
  localparam logic [3:0] MOD_STK = 4'hd;
  localparam logic [3:0] MOD_RSVD = 4'he;
  localparam logic [3:0] MOD_DP = 4'hf;
  localparam logic [4:0] IDX_AP = 5'h00;
  localparam logic [4:0] IDX_JUMP = 5'h00;
  localparam logic [4:0] IDX_CALL = 5'h01;
  localparam logic [4:0] IDX_STACK = 5'h00;
  localparam logic [4:0] IDX_SP = 5'h01;
  localparam logic [4:0] IDX_POUT = 5'h00;
  localparam logic [4:0] IDX_PDIR = 5'h01;
  localparam logic [4:0] IDX_PIN = 5'h02;
  localparam logic [4:0] IDX_RPIN = 5'h03;
  localparam logic [1:0] MM_HARVARD = 2'h0;
  localparam logic [1:0] MM_DATA_IN_CODE = 2'h1;
  localparam logic [1:0] MM_CODE_IN_DATA = 2'h2;
  localparam logic [IW-1:0] DATA_CODE_BASE = 16'h4000;
  localparam logic [IW-1:0] CODE_DATA_BASE = 16'h4000;
  // register bus map
  localparam int AXW = 8;
  localparam logic [AXW-1:0] REG_CTRL = 8'h00;
  localparam logic [AXW-1:0] REG_STAT = 8'h04;
  localparam logic [AXW-1:0] REG_PC = 8'h08;
  localparam logic [AXW-1:0] REG_KEY = 8'h0c;
  localparam logic [AXW-1:0] REG_ACC = 8'h10;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_RESET_PIN_DISABLE_BIT = 1;
  localparam int CTRL_MM_LSB = 2;
  localparam int CTRL_PWL = 4;
  localparam logic [7:0] CTRL_RESET = 8'h11;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR
  } tmid_alu_t;
  typedef struct packed {
    logic req;
    logic we;
    logic code_space;
    logic [IW-1:0] addr;
    logic [IW-1:0] wdata;
  } tmid_mreq_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [MODW-1:0] mod;
    logic [4:0] idx;
    logic [IW-1:0] wdata;
  } tmid_preg_t;
endpackage

// ---- tmid_code_mem.sv ----
// partner model: program memory, data memory and outside registers
`timescale 1ns/1ns
module tmid_code_mem (
  input wire logic aclk,
  input wire logic [15:0] code_addr,
  output logic [15:0] instr,
  input wire tmid_pkg::tmid_mreq_t dmem,
  output logic [15:0] dmem_rdata,
  input wire tmid_pkg::tmid_preg_t preg,
  output logic [15:0] preg_rdata
);
  import tmid_pkg::*;
  logic [IW-1:0] prog [0:255];
  logic [IW-1:0] data [0:255];
  logic [IW-1:0] churn_q = 16'h0000;
  // one whole word per fetch, answered in the same cycle
  assign instr = prog[code_addr[7:0]];
  // idle read lines churn so a stale value never looks valid
  assign dmem_rdata = dmem.req ? data[dmem.addr[7:0]] : churn_q;
  assign preg_rdata = preg.rd ? {11'h000, preg.idx} : ~churn_q;
  always_ff @(posedge aclk) begin
    churn_q <= churn_q + 16'h0001;
    if (dmem.req && dmem.we) begin
      data[dmem.addr[7:0]] <= dmem.wdata;
    end
  end
endmodule

// ---- tb_transport_move_instruction_decoder.sv ----
// testbench: program run, pin defaults, key and register bus
`timescale 1ns/1ns
module tb_transport_move_instruction_decoder;
  import tmid_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  logic bready = 1'b1;
  logic rready = 1'b1;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, rd_v;
  logic [1:0] rsp;
  logic [15:0] code_addr, instr, dmem_rdata, preg_rdata;
  logic code_from_data, prog_access_en, core_reset;
  logic rpin_out, rpin_oe_n, rpin_pullup;
  logic rpin_in = 1'b1;
  logic [7:0] port_in = 8'h5a;
  logic [7:0] port_out, port_oe_n, port_pullup;
  logic [255:0] pwd_words;
  tmid_mreq_t dmem;
  tmid_preg_t preg;
  int err_total = 0;
  int checks_done = 0;
  // ap=8, prefix, acc8=5, acc0, add 3, sub 9, xor 0f, push acc8,
  // dp0=10, mem=3c post-inc, acc1=mem pre-dec, pop acc2, add acc1,
  // xor acc2, port out a5, port dir 0f, park
  logic [15:0] pg [17] = '{16'h0808, 16'h0b01, 16'h0905, 16'h0977,
    16'h0a03, 16'h1a09, 16'h4a0f, 16'h8d89, 16'h0f10, 16'h073c,
    16'h99c7, 16'ha90d, 16'h8a19, 16'hca29, 16'h01a5, 16'h110f,
    16'h0c10};
  tmid_core tmid_core_i (.aclk, .aresetn, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .code_addr,
    .code_from_data, .instr, .dmem, .dmem_rdata, .preg, .preg_rdata,
    .pwd_words, .prog_access_en, .core_reset, .rpin_in, .rpin_out,
    .rpin_oe_n, .rpin_pullup, .port_in, .port_out, .port_oe_n,
    .port_pullup);
  tmid_code_mem tmid_code_mem_i (.aclk, .code_addr, .instr, .dmem,
    .dmem_rdata, .preg, .preg_rdata);
  initial begin
    forever #10 aclk = ~aclk;
  end
  task automatic chk(input string nm, input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  // ***********************
  // register bus master
  // ***********************
  // handshakes are judged at the falling edge, where all is settled
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ah, wh, bh;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(negedge aclk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      bh = bvalid;
      rsp = bresp;
      @(posedge aclk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
    end while (!bh);
  endtask
  task automatic rd(input logic [7:0] a);
    logic ah, rh;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(negedge aclk);
      ah = arvalid && arready;
      rh = rvalid;
      rd_v = rdata;
      rsp = rresp;
      @(posedge aclk);
      if (ah) arvalid <= 1'b0;
    end while (!rh);
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge aclk);
    err_total++;
    stop_test;
  end
  initial begin
    for (int i = 0; i < 256; i++) begin
      tmid_code_mem_i.prog[i] = (i < 17) ? pg[i] : 16'h0c10;
    end
    for (int n = 0; n < 16; n++) begin
      pwd_words[16*n +: 16] <= 16'hc3c0 + 16'(n);
    end
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (20) @(posedge aclk);
    rd(REG_PC);
    chk("pc", rd_v, 32'h10);
    rd(REG_ACC);
    chk("acc", {20'h0, rd_v[11:0]}, 32'h8dc);
    rd(REG_STAT);
    chk("stat", rd_v, 32'h0000000b);
    chk("mem", {16'h0, tmid_code_mem_i.data[16]}, 32'h3c);
    rd(REG_CTRL);
    chk("ctrl", {24'h0, rd_v[7:0]}, {24'h0, CTRL_RESET});
    chk("pout", {24'h0, port_out}, 32'ha5);
    chk("oe_run", {24'h0, port_oe_n}, 32'hf0);
    chk("pu_run", {24'h0, port_pullup}, 32'hf0);
    chk("rpin_oe", {31'h0, rpin_oe_n}, 32'h1);
    chk("rpin_pu", {31'h0, rpin_pullup}, 32'h1);
    chk("lock", {31'h0, prog_access_en}, 32'h0);
    rd(8'h20);
    chk("rd_unmap", {30'h0, rsp}, {30'h0, RESP_SLVERR});
    wr(8'h20, 32'h0);
    chk("wr_unmap", {30'h0, rsp}, {30'h0, RESP_SLVERR});
    for (int n = 0; n < 16; n++) begin
      wr(REG_KEY, {16'h0, 16'hc3c0 + 16'(n)});
    end
    @(negedge aclk);
    chk("unlock", {31'h0, prog_access_en}, 32'h1);
    @(posedge aclk);
    rpin_in <= 1'b0;
    repeat (6) @(posedge aclk);
    chk("pinrst", {31'h0, core_reset}, 32'h1);
    chk("oe", {24'h0, port_oe_n}, 32'hff);
    chk("pu", {24'h0, port_pullup}, 32'hff);
    rd(REG_PC);
    chk("pc_held", rd_v, 32'h0);
    rpin_in <= 1'b1;
    wr(REG_CTRL, 32'h13);
    rpin_in <= 1'b0;
    repeat (6) @(posedge aclk);
    chk("pin_io", {31'h0, core_reset}, 32'h0);
    stop_test;
  end
endmodule
